// [pkg/admd_pkg.sv]
// Constants and types for the accumulator data-move decoder
// Function
// - Opcode 00100011 plus byte loads that byte into accumulator; two cycles, flags kept.
// - Opcode 11111rrr copies selected working register into accumulator in one cycle.
// - Opcode 1111000r loads accumulator from data memory addressed by pointer register.
// - Opcode 11000111 copies program status word into accumulator, flags unchanged.
// - Opcode 10111rrr plus byte writes that byte into selected working register.
package admd_pkg;
    // ------------------------------------------------------------
    // Opcodes and masks
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_LOAD_ACC_IMM = 8'h23;
    localparam logic [7:0] OPC_ACC_FROM_REG = 8'hF8;
    localparam logic [7:0] MSK_REG_SEL = 8'hF8;
    localparam logic [7:0] OPC_ACC_FROM_PTR = 8'hF0;
    localparam logic [7:0] MSK_PTR_SEL = 8'hFE;
    localparam logic [7:0] OPC_ACC_FROM_PSW = 8'hC7;
    localparam logic [7:0] OPC_LOAD_REG_IMM = 8'hB8;
    // ------------------------------------------------------------
    // Status word and memory layout
    // ------------------------------------------------------------
    localparam int PSW_BANK_BIT = 4;
    localparam logic [7:0] BANK0_BASE = 8'h00;
    localparam logic [7:0] BANK1_BASE = 8'h18;
    localparam logic [7:0] PSW_RESET = 8'h08;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam int DMEM_DEPTH = 64;
    localparam int DMEM_AW = 6;
    typedef enum logic [1:0] {
        ADMD_FETCH,
        ADMD_ACC_IMM,
        ADMD_REG_IMM
    } admd_state_t;
endpackage : admd_pkg

// [rtl/admd_bank_addr.sv]
// Working register address resolution within the selected bank
`timescale 1ns/1ps
module admd_bank_addr (
    input wire logic bank_sel_i,
    input wire logic [2:0] reg_sel_i,
    output logic [7:0] addr_o
);
    wire logic [7:0] base;
    assign base = bank_sel_i ? admd_pkg::BANK1_BASE : admd_pkg::BANK0_BASE;
    assign addr_o = base + {5'h00, reg_sel_i};
endmodule : admd_bank_addr

// [rtl/admd_decoder.sv]
// Accumulator data-move decoder and executor with internal data memory
`timescale 1ns/1ps
module admd_decoder (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] prog_byte_i,
    input wire logic prog_valid_i,
    input wire logic [7:0] psw_wr_data_i,
    input wire logic psw_wr_i,
    output logic [7:0] acc_o,
    output logic [7:0] program_status_word_o,
    output logic busy_o,
    output logic done_o
);
    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    admd_pkg::admd_state_t state_ff, nxt_state;
    logic [7:0] acc_ff;
    logic [7:0] psw_ff;
    logic busy_ff;
    logic done_ff;
    logic [2:0] reg_sel_ff;
    logic [7:0] dmem [admd_pkg::DMEM_DEPTH];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic fetch = (state_ff == admd_pkg::ADMD_FETCH) && prog_valid_i;
    wire logic is_acc_imm = (prog_byte_i == admd_pkg::OPC_LOAD_ACC_IMM);
    wire logic is_acc_reg = ((prog_byte_i & admd_pkg::MSK_REG_SEL) == admd_pkg::OPC_ACC_FROM_REG);
    wire logic is_acc_ptr = ((prog_byte_i & admd_pkg::MSK_PTR_SEL) == admd_pkg::OPC_ACC_FROM_PTR);
    wire logic is_acc_psw = (prog_byte_i == admd_pkg::OPC_ACC_FROM_PSW);
    wire logic is_reg_imm = ((prog_byte_i & admd_pkg::MSK_REG_SEL) == admd_pkg::OPC_LOAD_REG_IMM);
    wire logic bank_sel = psw_ff[admd_pkg::PSW_BANK_BIT];

    // Register-form address uses low three bits; pointer form uses bit 0 only
    wire logic [2:0] op_reg = is_acc_ptr ? {2'h0, prog_byte_i[0]} : prog_byte_i[2:0];
    wire logic [2:0] wr_sel = reg_sel_ff;
    wire logic [7:0] rd_addr;
    wire logic [7:0] wr_addr;

    admd_bank_addr u_rd_addr (
        .bank_sel_i(bank_sel),
        .reg_sel_i(op_reg),
        .addr_o(rd_addr)
    );
    admd_bank_addr u_wr_addr (
        .bank_sel_i(bank_sel),
        .reg_sel_i(wr_sel),
        .addr_o(wr_addr)
    );

    wire logic [7:0] reg_val = dmem[rd_addr[admd_pkg::DMEM_AW-1:0]];
    // Pointer contents index the full data memory; upper address bits beyond depth wrap
    wire logic [7:0] ptr_val = dmem[reg_val[admd_pkg::DMEM_AW-1:0]];
    wire logic second = prog_valid_i && (state_ff != admd_pkg::ADMD_FETCH);
    wire logic wr_reg = second && (state_ff == admd_pkg::ADMD_REG_IMM);

    // ------------------------------------------------------------
    // Next-state and accumulator selection
    // ------------------------------------------------------------
    logic [7:0] nxt_acc;
    always_comb begin
        nxt_state = state_ff;
        nxt_acc = acc_ff;
        case (state_ff)
            admd_pkg::ADMD_FETCH: begin
                if (fetch) begin
                    if (is_acc_imm) begin
                        nxt_state = admd_pkg::ADMD_ACC_IMM;
                    end else if (is_reg_imm) begin
                        nxt_state = admd_pkg::ADMD_REG_IMM;
                    end else if (is_acc_reg) begin
                        nxt_acc = reg_val;
                    end else if (is_acc_ptr) begin
                        nxt_acc = ptr_val;
                    end else if (is_acc_psw) begin
                        nxt_acc = psw_ff;
                    end
                end
            end
            admd_pkg::ADMD_ACC_IMM: begin
                if (prog_valid_i) begin
                    nxt_acc = prog_byte_i;
                    nxt_state = admd_pkg::ADMD_FETCH;
                end
            end
            admd_pkg::ADMD_REG_IMM: begin
                if (prog_valid_i) begin
                    nxt_state = admd_pkg::ADMD_FETCH;
                end
            end
            default: begin
                nxt_state = admd_pkg::ADMD_FETCH;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Completion and busy
    // ------------------------------------------------------------
    // One-byte members of the group finish at the opcode edge
    wire logic one_byte_hit = fetch && (is_acc_reg || is_acc_ptr || is_acc_psw);

    // Two-byte members finish when the immediate byte is taken
    wire logic two_byte_end = second;

    // Opcodes outside the group raise neither flag
    wire logic nxt_done = one_byte_hit || two_byte_end;

    // Busy stands from the opcode edge until the immediate edge, stalls included
    wire logic nxt_busy = (nxt_state != admd_pkg::ADMD_FETCH);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Sequencer state: fetch, or waiting for an immediate byte
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= admd_pkg::ADMD_FETCH;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Accumulator only moves when a load of this group completes
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            acc_ff <= admd_pkg::ACC_RESET;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // Registered so the output comes straight from a flop
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    // One-cycle completion pulse
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
        end
    end

    // Register number is latched at the opcode because the immediate may follow stall cycles
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_sel_ff <= 3'h0;
        end else if (fetch) begin
            reg_sel_ff <= prog_byte_i[2:0];
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    // Flags are never touched by this group; only an external status write changes them
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            psw_ff <= admd_pkg::PSW_RESET;
        end else if (psw_wr_i) begin
            psw_ff <= psw_wr_data_i;
        end
    end

    // ------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------
    // Memory has no reset: contents are undefined at power-up, so write before reading
    always_ff @(posedge core_clk_i) begin
        if (wr_reg) begin
            dmem[wr_addr[admd_pkg::DMEM_AW-1:0]] <= prog_byte_i;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign acc_o = acc_ff;
    assign program_status_word_o = psw_ff;
    assign busy_o = busy_ff;
    assign done_o = done_ff;
endmodule : admd_decoder

// [verification/admd_prog_mem.sv]
// Program memory model presenting instruction bytes
`timescale 1ns/1ps
module admd_prog_mem (
    input wire logic core_clk_i,
    input wire logic run_i,
    input wire logic slow_i,
    input wire logic [3:0] len_i,
    output logic [7:0] prog_byte_o,
    output logic prog_valid_o,
    output logic [3:0] pc_o
);
    logic [7:0] rom [4];
    logic gap;
    initial begin
        prog_valid_o = 1'b0;
        prog_byte_o = 8'h00;
        pc_o = 4'h0;
    end
    // Idle bytes are inverted so stale data never looks like a fresh byte
    always @(posedge core_clk_i) begin
        #3;
        gap = slow_i && prog_valid_o;
        if (!run_i) pc_o = 4'h0;
        prog_valid_o = run_i && !gap && pc_o < len_i;
        prog_byte_o = prog_valid_o ? rom[pc_o[1:0]] : ~prog_byte_o;
        pc_o = pc_o + {3'h0, prog_valid_o};
    end
endmodule : admd_prog_mem

// [verification/admd_checker_sva.sv]
// Port assertions for the accumulator data-move decoder
`timescale 1ns/1ps
module admd_checker_sva (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] prog_byte_i,
    input wire logic prog_valid_i,
    input wire logic psw_wr_i,
    input wire logic [7:0] acc_o,
    input wire logic [7:0] program_status_word_o,
    input wire logic busy_o,
    input wire logic done_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic op = rst_n_i && !busy_o && prog_valid_i && !psw_wr_i;
    imm_acc_a: assert property (op && prog_byte_i == 8'h23 ##1 prog_valid_i |=> acc_o == $past(prog_byte_i) && done_o)
        else $error("immediate byte not in accumulator");
    reg_acc_a: assert property (op && prog_byte_i[7:3] == 5'h1F |=> done_o && !busy_o)
        else $error("register load not one cycle");
    ptr_acc_a: assert property (op && prog_byte_i[7:1] == 7'h78 |=> done_o && !busy_o)
        else $error("indirect load not one cycle");
    psw_acc_a: assert property (op && prog_byte_i == 8'hC7 |=> acc_o == $past(program_status_word_o) && done_o)
        else $error("status word not in accumulator");
    reg_imm_a: assert property (op && prog_byte_i[7:3] == 5'h17 |=> busy_o && !done_o && $stable(acc_o))
        else $error("register immediate did not wait");
    bank_kept_a: assert property (!psw_wr_i |=> $stable(program_status_word_o))
        else $error("status word changed");
    cover property (op && prog_byte_i == 8'h23);
    cover property (busy_o && !prog_valid_i);
    cover property (done_o && program_status_word_o[4]);
endmodule : admd_checker_sva
bind admd_decoder admd_checker_sva u_sva (.*);

// [verification/accumulator_data_move_decoder_test.sv]
// Self-checking bench for the accumulator data-move decoder
`timescale 1ns/1ps
module accumulator_data_move_decoder_test;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psw_wr_i = 1'b0;
    logic [7:0] psw_wr_data_i = 8'h00;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic [3:0] len = 4'h0;
    logic [3:0] pc;
    logic [7:0] prog_byte_i, acc_o, program_status_word_o;
    logic prog_valid_i, busy_o, done_o;
    logic done_seen = 1'b0;
    logic busy_seen = 1'b0;
    int errors = 0;
    int n_checks = 0;
    admd_decoder dut (.*);
    admd_prog_mem pm (.core_clk_i(core_clk_i), .run_i(run), .slow_i(slow), .len_i(len),
        .prog_byte_o(prog_byte_i), .prog_valid_o(prog_valid_i), .pc_o(pc));
    initial forever #20 core_clk_i = ~core_clk_i;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // Feed up to three bytes, then let the last result land
    task run_prog(input logic [23:0] code, input logic [3:0] n, input logic s);
        int i;
        for (i = 0; i < 3; i++) pm.rom[i] = code[23-8*i -: 8];
        len = n;
        slow = s;
        run = 1'b1;
        for (i = 0; i < 20 && pc !== n; i++) @(posedge core_clk_i);
        if (i == 20) begin
            errors++;
            give_verdict;
        end
        #1;
        done_seen = done_o;
        busy_seen = busy_o;
        @(posedge core_clk_i);
        #1 run = 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask : run_prog
    task t_regs;
        for (int r = 0; r < 8; r++) begin
            run_prog({5'h17, 3'(r), 8'h30 + 8'(r), 5'h1F, 3'(r)}, 4'h3, r[0]);
            check(acc_o, 8'h30 + 8'(r));
        end
        run_prog(24'hF80000, 4'h1, 1'b0);
        check(acc_o, 8'h30);
        check({7'h00, done_seen}, 8'h01);
        check({7'h00, busy_seen}, 8'h00);
    endtask : t_regs
    task t_more;
        run_prog(24'h23A500, 4'h2, 1'b1);
        check(acc_o, 8'hA5);
        check({7'h00, done_seen}, 8'h01);
        run_prog(24'hB805F0, 4'h3, 1'b0);
        check(acc_o, 8'h35);
        run_prog(24'hB902F1, 4'h3, 1'b1);
        check(acc_o, 8'h32);
        psw_wr_data_i = 8'h18;
        psw_wr_i = 1'b1;
        @(posedge core_clk_i);
        #1 psw_wr_i = 1'b0;
        run_prog(24'hB83CC7, 4'h3, 1'b0);
        check(acc_o, 8'h18);
        check(program_status_word_o, 8'h18);
        run_prog(24'hF80000, 4'h1, 1'b0);
        check(acc_o, 8'h3C);
    endtask : t_more
    initial begin
        repeat (16) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        check(program_status_word_o, 8'h08);
        run_prog(24'h235A00, 4'h2, 1'b0);
        check(acc_o, 8'h5A);
        t_regs;
        t_more;
        give_verdict;
    end
endmodule : accumulator_data_move_decoder_test
